// [logic/bsl_boot_strap_latch.sv]
// boot strap latch: captures five strap pins at reset release, decodes
// them into boot settings and offers them over an apb slave.
// assumes RESET_N_I is the system reset (power-on, watchdog, brownout)
// and that pad cells resolve level from out, oe and pull enables.
// Behaviour
// - latch five strap levels at reset release, keep until the next system reset
// - software reads all five latched bits from a read-only register
// - weak default pulls on strap pins while reset is asserted
// - after release pins return to normal function, latched bits kept
// - ldo strap 0 selects 3.3 V, 1 selects 1.8 V
// - boot-select 1 boots flash; 0 with aux 0 boots download
// - log and sdio-edge straps pick sdio sample and output edges
// - firmware may override ldo and sdio settings, straps unchanged
// - software may power off the flash-supply regulator
`default_nettype none
module bsl_boot_strap_latch (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // strap pads
  input wire logic [4:0] STRAP_PIN_I,
  output logic [4:0] STRAP_PIN_O,
  output logic [4:0] STRAP_PIN_OE_O,
  output logic [4:0] STRAP_PULL_UP_O,
  output logic [4:0] STRAP_PULL_DN_O,
  // functional side of the pads
  input wire logic [4:0] GPIO_OUT_I,
  input wire logic [4:0] GPIO_OE_I,
  output logic [4:0] GPIO_IN_O,
  // console transmit
  input wire logic CONSOLE_TX_I,
  output logic BOOT_CONSOLE_TX_O,
  // decoded settings
  output logic LDO_SEL_1V8_O,
  output logic LDO_ENABLE_O,
  output logic BOOT_FLASH_O,
  output logic BOOT_DOWNLOAD_O,
  output logic BOOT_RESERVED_O,
  output logic BOOT_LOG_EN_O,
  output logic SDIO_SAMPLE_RISE_O,
  output logic SDIO_OUTPUT_RISE_O,
  output logic STRAP_DONE_O
);

  bsl_pkg::bsl_state_t state_reg, state_next;
  logic [1:0] settle_reg;
  logic [4:0] sync1_reg, sync2_reg, strap_reg;
  logic [4:0] pull_up_reg, pull_dn_reg, pin_out_reg, pin_oe_reg;
  logic [6:0] ctrl_reg;
  logic [8:0] stat_next, stat_reg;
  logic [31:0] prdata_reg;
  logic done_reg, pready_reg, pslverr_reg, tx_reg, access, wr_fire;

  // register hit test for the error answer; the read mux decodes on its own
  function automatic logic bsl_hit(input logic [11:0] a);
    bsl_hit = (a == bsl_pkg::REG_VALUE) || (a == bsl_pkg::REG_CTRL)
      || (a == bsl_pkg::REG_STATUS);
  endfunction

  // two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end
    else
    begin
      sync1_reg <= STRAP_PIN_I;
      sync2_reg <= sync1_reg;
    end
  end

  // capture sequencer: wait for the synchroniser, sample once, run
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      bsl_pkg::ST_HOLD:
        if (settle_reg == bsl_pkg::SETTLE_CYCLES)
          state_next = bsl_pkg::ST_SAMPLE;
      bsl_pkg::ST_SAMPLE:
        state_next = bsl_pkg::ST_RUN;
      bsl_pkg::ST_RUN: state_next = bsl_pkg::ST_RUN;
      default:
        state_next = bsl_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_reg <= bsl_pkg::ST_HOLD;
      settle_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == bsl_pkg::ST_HOLD)
        settle_reg <= settle_reg + 2'h1;
    end
  end

  // latch once; only a new system reset can reopen it
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      strap_reg <= 5'h00;
      done_reg <= 1'h0;
    end
    else if (state_reg == bsl_pkg::ST_SAMPLE)
    begin
      strap_reg <= sync2_reg;
      done_reg <= 1'h1;
    end
  end

  // pad control: pulls until sampled, then the functional path owns it
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      pull_up_reg <= bsl_pkg::PULL_UP_MASK;
      pull_dn_reg <= bsl_pkg::PULL_DN_MASK;
      pin_out_reg <= 5'h00;
      pin_oe_reg <= 5'h00;
    end
    else if (done_reg)
    begin
      pull_up_reg <= 5'h00;
      pull_dn_reg <= 5'h00;
      pin_out_reg <= GPIO_OUT_I;
      pin_oe_reg <= GPIO_OE_I;
    end
  end

  // apb handshake: one wait state so every answer comes from a flop
  assign access = PSEL_I && PENABLE_I;
  assign wr_fire = access && pready_reg && PWRITE_I;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      pready_reg <= 1'h0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'h0;
    end
    else
    begin
      pready_reg <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !bsl_hit(PADDR_I);
      if (access && !pready_reg && !PWRITE_I)
      begin
        if (PADDR_I == bsl_pkg::REG_VALUE)
          prdata_reg <= {27'h0, strap_reg};
        else if (PADDR_I == bsl_pkg::REG_CTRL)
          prdata_reg <= {25'h0, ctrl_reg};
        else if (PADDR_I == bsl_pkg::REG_STATUS)
          prdata_reg <= {23'h0, stat_reg};
        else
          prdata_reg <= 32'h0000_0000;
      end
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  // control register; writes to the value register are ignored
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      ctrl_reg <= bsl_pkg::CTRL_RESET;
    else if (wr_fire && PADDR_I == bsl_pkg::REG_CTRL)
      ctrl_reg <= PWDATA_I[6:0];
  end

  // effective settings: strap decode unless firmware overrides
  always_comb
  begin
    stat_next = 9'h000;
    stat_next[bsl_pkg::ST_DONE] = done_reg;
    stat_next[bsl_pkg::ST_LDO_ON] = !ctrl_reg[bsl_pkg::CTRL_LDO_OFF];
    if (ctrl_reg[bsl_pkg::CTRL_LDO_OVR])
      stat_next[bsl_pkg::ST_LDO_1V8] = ctrl_reg[bsl_pkg::CTRL_LDO_1V8];
    else
      stat_next[bsl_pkg::ST_LDO_1V8] = strap_reg[bsl_pkg::BIT_LDO];
    if (done_reg && strap_reg[bsl_pkg::BIT_BSEL])
      stat_next[bsl_pkg::ST_BOOT_FLASH] = 1'h1;
    else if (done_reg && !strap_reg[bsl_pkg::BIT_BAUX])
      stat_next[bsl_pkg::ST_BOOT_DL] = 1'h1;
    else if (done_reg)
      stat_next[bsl_pkg::ST_BOOT_RSVD] = 1'h1;
    stat_next[bsl_pkg::ST_LOG_EN] = strap_reg[bsl_pkg::BIT_LOG];
    if (ctrl_reg[bsl_pkg::CTRL_SDIO_OVR])
    begin
      stat_next[bsl_pkg::ST_SMP_RISE] = ctrl_reg[bsl_pkg::CTRL_SMP_RISE];
      stat_next[bsl_pkg::ST_OUT_RISE] = ctrl_reg[bsl_pkg::CTRL_OUT_RISE];
    end
    else
    begin
      stat_next[bsl_pkg::ST_SMP_RISE] = strap_reg[bsl_pkg::BIT_LOG];
      stat_next[bsl_pkg::ST_OUT_RISE] = strap_reg[bsl_pkg::BIT_SDIO];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      stat_reg <= 9'h000;
    else
      stat_reg <= stat_next;
  end

  // console gate: silent during boot unless the log strap allows it
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      tx_reg <= bsl_pkg::TX_IDLE;
    else if (ctrl_reg[bsl_pkg::CTRL_BOOT_DONE] || strap_reg[bsl_pkg::BIT_LOG])
      tx_reg <= CONSOLE_TX_I;
    else
      tx_reg <= bsl_pkg::TX_IDLE;
  end

  // outputs, all from flops
  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign STRAP_PIN_O = pin_out_reg;
  assign STRAP_PIN_OE_O = pin_oe_reg;
  assign STRAP_PULL_UP_O = pull_up_reg;
  assign STRAP_PULL_DN_O = pull_dn_reg;
  assign GPIO_IN_O = sync2_reg;
  assign BOOT_CONSOLE_TX_O = tx_reg;
  assign LDO_SEL_1V8_O = stat_reg[bsl_pkg::ST_LDO_1V8];
  assign LDO_ENABLE_O = stat_reg[bsl_pkg::ST_LDO_ON];
  assign BOOT_FLASH_O = stat_reg[bsl_pkg::ST_BOOT_FLASH];
  assign BOOT_DOWNLOAD_O = stat_reg[bsl_pkg::ST_BOOT_DL];
  assign BOOT_RESERVED_O = stat_reg[bsl_pkg::ST_BOOT_RSVD];
  assign BOOT_LOG_EN_O = stat_reg[bsl_pkg::ST_LOG_EN];
  assign SDIO_SAMPLE_RISE_O = stat_reg[bsl_pkg::ST_SMP_RISE];
  assign SDIO_OUTPUT_RISE_O = stat_reg[bsl_pkg::ST_OUT_RISE];
  assign STRAP_DONE_O = stat_reg[bsl_pkg::ST_DONE];

  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  property p_latch_hold;
    done_reg |=> done_reg && $stable(strap_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("strap bits changed after capture");
  property p_latch_time;
    $rose(RESET_N_I) |-> ##4 done_reg && strap_reg == $past(sync2_reg);
  endproperty
  a_latch_time: assert property (p_latch_time)
    else $error("strap capture not taken at the fourth edge");
  property p_read_value;
    pready_reg && !PWRITE_I && PADDR_I == bsl_pkg::REG_VALUE
      |-> PRDATA_O == {27'h0, strap_reg};
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("strap value read mismatch");
  property p_pulls;
    !done_reg |-> STRAP_PULL_UP_O == bsl_pkg::PULL_UP_MASK
      && STRAP_PULL_DN_O == bsl_pkg::PULL_DN_MASK && STRAP_PIN_OE_O == 5'h00;
  endproperty
  a_pulls: assert property (p_pulls)
    else $error("default pulls missing before capture");
  property p_release;
    done_reg ##1 done_reg |-> STRAP_PULL_UP_O == 5'h00
      && STRAP_PIN_OE_O == $past(GPIO_OE_I);
  endproperty
  a_release: assert property (p_release)
    else $error("pins not returned to functional use");
  property p_ldo;
    !ctrl_reg[bsl_pkg::CTRL_LDO_OVR] |=> LDO_SEL_1V8_O == $past(strap_reg[0]);
  endproperty
  a_ldo: assert property (p_ldo)
    else $error("regulator voltage does not follow strap");
  property p_boot;
    done_reg && strap_reg[1] |=> BOOT_FLASH_O && !BOOT_DOWNLOAD_O;
  endproperty
  a_boot: assert property (p_boot)
    else $error("flash boot not selected");
  property p_reserved;
    done_reg && strap_reg[2:1] == 2'h2
      |=> BOOT_RESERVED_O && !BOOT_FLASH_O && !BOOT_DOWNLOAD_O;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved boot combination not flagged");
  property p_silent;
    !strap_reg[3] && !ctrl_reg[bsl_pkg::CTRL_BOOT_DONE]
      |=> BOOT_CONSOLE_TX_O == bsl_pkg::TX_IDLE;
  endproperty
  a_silent: assert property (p_silent)
    else $error("console not silent during boot");
  property p_sdio;
    !ctrl_reg[bsl_pkg::CTRL_SDIO_OVR] |=> SDIO_SAMPLE_RISE_O ==
      $past(strap_reg[3]) && SDIO_OUTPUT_RISE_O == $past(strap_reg[4]);
  endproperty
  a_sdio: assert property (p_sdio)
    else $error("sdio edges do not follow straps");
  property p_override;
    wr_fire && PADDR_I == bsl_pkg::REG_CTRL && PWDATA_I[0]
      |=> ##1 LDO_SEL_1V8_O == $past(PWDATA_I[1], 2) && $stable(strap_reg);
  endproperty
  a_override: assert property (p_override)
    else $error("regulator override not applied");
  property p_ldo_off;
    ctrl_reg[bsl_pkg::CTRL_LDO_OFF] |=> !LDO_ENABLE_O;
  endproperty
  a_ldo_off: assert property (p_ldo_off)
    else $error("regulator not powered off");
  c_capture: cover property ($rose(done_reg));
  c_reserved: cover property (BOOT_RESERVED_O);
  c_override: cover property (wr_fire && PADDR_I == bsl_pkg::REG_CTRL);
  c_unmapped: cover property (PSLVERR_O && PREADY_O);
endmodule
`default_nettype wire

// [logic/bsl_pkg.sv]
// boot strap latch: shared constants, register map and state type
// assumes a 32-bit apb slave port and five strap pins
`default_nettype none
package bsl_pkg;
  // strap bit positions, one per pin
  localparam int unsigned STRAP_W = 5;
  localparam int unsigned BIT_LDO = 0;
  localparam int unsigned BIT_BSEL = 1;
  localparam int unsigned BIT_BAUX = 2;
  localparam int unsigned BIT_LOG = 3;
  localparam int unsigned BIT_SDIO = 4;
  // default pulls applied while reset holds the pins
  localparam logic [4:0] PULL_UP_MASK = 5'h1A;
  localparam logic [4:0] PULL_DN_MASK = 5'h05;
  // register byte addresses
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] REG_VALUE = 12'h000;
  localparam logic [11:0] REG_CTRL = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  // control register fields
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CTRL_LDO_OVR = 0;
  localparam int unsigned CTRL_LDO_1V8 = 1;
  localparam int unsigned CTRL_SDIO_OVR = 2;
  localparam int unsigned CTRL_SMP_RISE = 3;
  localparam int unsigned CTRL_OUT_RISE = 4;
  localparam int unsigned CTRL_LDO_OFF = 5;
  localparam int unsigned CTRL_BOOT_DONE = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  // status register fields
  localparam int unsigned STAT_W = 9;
  localparam int unsigned ST_LDO_1V8 = 0;
  localparam int unsigned ST_LDO_ON = 1;
  localparam int unsigned ST_BOOT_FLASH = 2;
  localparam int unsigned ST_BOOT_DL = 3;
  localparam int unsigned ST_BOOT_RSVD = 4;
  localparam int unsigned ST_LOG_EN = 5;
  localparam int unsigned ST_SMP_RISE = 6;
  localparam int unsigned ST_OUT_RISE = 7;
  localparam int unsigned ST_DONE = 8;
  // settle count that ends the hold state; synchronised pins sampled at the fourth edge after release
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  // idle level of the console transmit line
  localparam logic TX_IDLE = 1'h1;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_RUN = 3'b100
  } bsl_state_t;
endpackage
`default_nettype wire

// [sim/bsl_board_model.sv]
// board side of the strap pads: pull resistors or host gpio drive
// assumes the device pad controls come straight from the latch block
`default_nettype none
module bsl_board_model (
  // board drive
  input wire logic [4:0] lvl_i,
  input wire logic [4:0] drv_i,
  // device pad controls
  input wire logic [4:0] pin_o_i,
  input wire logic [4:0] pin_oe_i,
  input wire logic [4:0] pull_up_i,
  input wire logic [4:0] pull_dn_i,
  // resolved pad level
  output logic [4:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // device drive wins, then board level, then weak pulls
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (pin_oe_i[i])
        pad_o[i] = pin_o_i[i];
      else if (drv_i[i])
        pad_o[i] = lvl_i[i];
      else if (pull_up_i[i])
        pad_o[i] = 1'b1;
      else if (pull_dn_i[i])
        pad_o[i] = 1'b0;
      else
        pad_o[i] = ~lvl_i[i]; // floating: never a stale level
    end
  end
endmodule
`default_nettype wire

// [sim/bsl_testbench.sv]
// bench for the boot strap latch: strap rows, apb reads, overrides
// assumes apb answers with pready after a bounded number of waits
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] drv;
    logic [4:0] lvl;
    logic [4:0] strap;
    logic [8:0] st;
  } bsl_row_t;
  // board drive, levels, latched value, status word
  bsl_row_t rows [7] = '{
    '{5'h1F, 5'h1F, 5'h1F, 9'h1E7},
    '{5'h00, 5'h00, 5'h1A, 9'h1E6},
    '{5'h1F, 5'h04, 5'h04, 9'h112},
    '{5'h1F, 5'h10, 5'h10, 9'h18A},
    '{5'h1F, 5'h09, 5'h09, 9'h16B},
    '{5'h1F, 5'h06, 5'h06, 9'h106},
    '{5'h1F, 5'h00, 5'h00, 9'h10A}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] lvl = 5'h00;
  logic [4:0] drv = 5'h00;
  logic [4:0] gpio_out = 5'h00;
  logic [4:0] gpio_oe = 5'h00;
  logic con_tx = 1'b0;
  logic [31:0] rd;
  logic er;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic [4:0] pad;
  wire logic [4:0] pin_o;
  wire logic [4:0] pin_oe;
  wire logic [4:0] pup;
  wire logic [4:0] pdn;
  wire logic [4:0] gpio_in;
  wire logic con_o;
  wire logic [8:0] dec;
  int error_cnt = 0;
  int total_checks = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  bsl_boot_strap_latch dut (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .STRAP_PIN_I(pad), .STRAP_PIN_O(pin_o),
    .STRAP_PIN_OE_O(pin_oe), .STRAP_PULL_UP_O(pup),
    .STRAP_PULL_DN_O(pdn), .GPIO_OUT_I(gpio_out), .GPIO_OE_I(gpio_oe),
    .GPIO_IN_O(gpio_in), .CONSOLE_TX_I(con_tx),
    .BOOT_CONSOLE_TX_O(con_o), .LDO_SEL_1V8_O(dec[0]),
    .LDO_ENABLE_O(dec[1]), .BOOT_FLASH_O(dec[2]),
    .BOOT_DOWNLOAD_O(dec[3]), .BOOT_RESERVED_O(dec[4]),
    .BOOT_LOG_EN_O(dec[5]), .SDIO_SAMPLE_RISE_O(dec[6]),
    .SDIO_OUTPUT_RISE_O(dec[7]), .STRAP_DONE_O(dec[8]));
  bsl_board_model board (.lvl_i(lvl), .drv_i(drv), .pin_o_i(pin_o),
    .pin_oe_i(pin_oe), .pull_up_i(pup), .pull_dn_i(pdn), .pad_o(pad));
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stuck(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s timed out", $time, m);
    conclude();
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      stuck("apb");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // capture finishes a few edges after release; bound the wait
  task automatic wait_done();
    int n;
    n = 0;
    while (dec[8] !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
      stuck("capture");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_done();
    foreach (rows[i])
    begin
      @(posedge clk);
      // supervisor holds reset low while the supply is not yet good
      rst_n <= 1'b0;
      lvl <= rows[i].lvl;
      drv <= rows[i].drv;
      // 50 us hold also covers the wait after the supply rise
      repeat (5000) @(posedge clk);
      chk(pup, 5'h1A, "pull up");
      chk(pdn, 5'h05, "pull down");
      rst_n <= 1'b1;
      wait_done();
      chk(dec, rows[i].st, "decodes");
      apb(1'b0, bsl_pkg::REG_VALUE, 32'h0, rd, er);
      chk(rd, rows[i].strap, "strap value");
      chk(er, 1'b0, "mapped read error");
      apb(1'b0, bsl_pkg::REG_STATUS, 32'h0, rd, er);
      chk(rd, rows[i].st, "status");
      chk(con_o, !rows[i].strap[3], "console");
      chk(pup | pdn, 5'h00, "pulls off");
      $display("row %0d done, errors %0d", i, error_cnt);
    end
    // pins move after capture and software pokes the read-only word
    lvl <= 5'h1F;
    apb(1'b1, bsl_pkg::REG_VALUE, 32'h1F, rd, er);
    chk(er, 1'b0, "read-only write error");
    apb(1'b0, bsl_pkg::REG_VALUE, 32'h0, rd, er);
    chk(rd, 32'h0, "strap kept");
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk(er, 1'b1, "unmapped");
    // firmware override of regulator and sdio edges
    apb(1'b1, bsl_pkg::REG_CTRL, 32'h1F, rd, er);
    apb(1'b0, bsl_pkg::REG_CTRL, 32'h0, rd, er);
    chk(rd, 32'h1F, "ctrl readback");
    chk({dec[7:6], dec[0]}, 3'h7, "override");
    apb(1'b0, bsl_pkg::REG_VALUE, 32'h0, rd, er);
    chk(rd, 32'h0, "strap under override");
    apb(1'b1, bsl_pkg::REG_CTRL, 32'h3F, rd, er);
    repeat (2) @(posedge clk);
    chk(dec[1], 1'b0, "regulator off");
    chk(con_o, 1'b1, "console silent");
    apb(1'b1, bsl_pkg::REG_CTRL, 32'h40, rd, er);
    repeat (2) @(posedge clk);
    chk(con_o, 1'b0, "console after boot");
    chk(dec[7:0], 8'h0A, "override dropped");
    // pads back in functional use
    drv <= 5'h00;
    gpio_oe <= 5'h1F;
    gpio_out <= 5'h15;
    repeat (4) @(posedge clk);
    chk(pin_oe, 5'h1F, "pad enable");
    chk(pin_o, 5'h15, "pad out");
    chk(gpio_in, 5'h15, "pad in");
    $display("hand tests done, errors %0d", error_cnt);
    conclude();
  end
endmodule
`default_nettype wire
